// [inc/bit_branch_pkg.sv]
package bit_branch_pkg;

   // bit addresses below this one live in lower internal ram
   localparam logic [7:0] SFR_BIT_BASE   = 8'h80;
   // lower ram byte that holds bit address 00h
   localparam logic [7:0] BIT_RAM_BASE   = 8'h20;
   // carry is bit 7 of the status word at sfr byte d0h
   localparam logic [7:0] CARRY_BIT_ADDR = 8'hD7;
   localparam logic       CARRY_RESET    = 1'b0;
   localparam int         PAGE_BITS      = 11;

   typedef enum logic [4:0] {
      op_and_logic_bit,
      op_and_logic_not_bit,
      op_or_logic_bit,
      op_or_logic_not_bit,
      op_transfer_bit_to_carry,
      op_transfer_carry_to_bit,
      op_clear_bit_carry,
      op_clear_bit,
      op_force_bit_high_carry,
      op_force_bit_high,
      op_invert_bit_carry,
      op_invert_bit,
      op_branch_if_carry,
      op_branch_if_no_carry,
      op_branch_if_bit_high,
      op_branch_if_bit_low,
      op_branch_and_clear_bit,
      op_short_relative_jump,
      op_long_absolute_jump,
      op_page_absolute_jump,
      op_indexed_jump,
      op_long_subroutine_call,
      op_page_subroutine_call,
      op_subroutine_exit,
      op_interrupt_service_exit,
      op_branch_acc_zero,
      op_branch_acc_nonzero,
      op_count_down_branch,
      op_compare_branch_unequal
   } op_t;

endpackage

// [src/bit_branch_unit.sv]
// What this block does
// - bits 00h-7Fh lower ram, 80h-FFh sfr
// - port lines reached as sfr bits
// - carry is accumulator, also at bit address
// - and, or, not forms, copy, clear, set, invert
// - no exclusive-or bit operation
// - branch on carry or bit, set or clear
// - test-and-clear branch clears a set bit
// - every status word bit is bit addressable
// - relative target is next pc plus signed offset
// - short jump: opcode plus one offset byte
// - long jump: full 16-bit target
// - page jump replaces low 11 pc bits
// - indexed jump: data pointer plus unsigned acc
// - long call 16-bit, page call 11-bit target
// - return resumes after the calling instruction
// - interrupt exit also notifies interrupt control when irq_in_progress is set
// - zero branches test accumulator directly
// - count down, branch when result nonzero
// - compare branches only when operands differ
// - unsigned compare: carry set when first smaller
`timescale 1ns/1ps

module bit_branch_unit
   import bit_branch_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                start,
   input  wire bit_branch_pkg::op_t op,
   input  wire logic [7:0]          bit_addr,
   input  wire logic [7:0]          byte_addr,
   input  wire logic [7:0]          acc,
   input  wire logic [7:0]          operand_a,
   input  wire logic [7:0]          operand_b,
   input  wire logic [7:0]          rel_offset,
   input  wire logic [2:0]          page_bits,
   input  wire logic [7:0]          addr_hi,
   input  wire logic [7:0]          addr_lo,
   input  wire logic [15:0]         pc_next,
   input  wire logic [15:0]         data_pointer,
   input  wire logic [15:0]         pop_addr,
   input  wire logic                irq_in_progress,
   input  wire logic [7:0]          mem_rdata,
   output logic [7:0]               mem_addr,
   output logic                     mem_sfr,
   output logic                     mem_rd,
   output logic                     mem_wr,
   output logic [7:0]               mem_wdata,
   output logic                     carry,
   output logic                     pc_load,
   output logic [15:0]              pc_target,
   output logic                     push_req,
   output logic [15:0]              push_addr,
   output logic                     irq_done,
   output logic                     done
);
   import bit_branch_pkg::*;

   typedef enum logic [1:0] {st_idle, st_read, st_exec} state_t;

   state_t      state_reg, state_next;
   logic [7:0]  mem_addr_reg, mem_addr_next;
   logic        mem_sfr_reg, mem_sfr_next;
   logic        mem_rd_reg, mem_rd_next;
   logic        mem_wr_reg, mem_wr_next;
   logic [7:0]  mem_wdata_reg, mem_wdata_next;
   logic        carry_reg, carry_next;
   logic        pc_load_reg, pc_load_next;
   logic [15:0] pc_target_reg, pc_target_next;
   logic        push_req_reg, push_req_next;
   logic [15:0] push_addr_reg, push_addr_next;
   logic        irq_done_reg, irq_done_next;
   logic        done_reg, done_next;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // ops that read an addressed bit or write one
   function automatic logic uses_bit(input op_t o);
      unique case (o)
         op_and_logic_bit, op_and_logic_not_bit, op_or_logic_bit,
         op_or_logic_not_bit, op_transfer_bit_to_carry,
         op_transfer_carry_to_bit, op_clear_bit, op_force_bit_high,
         op_invert_bit, op_branch_if_bit_high, op_branch_if_bit_low,
         op_branch_and_clear_bit: uses_bit = 1'b1;
         default: uses_bit = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      if (b < SFR_BIT_BASE) begin
         bit_byte = BIT_RAM_BASE + {4'h0, b[6:3]};
      end else begin
         bit_byte = {b[7:3], 3'b000};
      end
   endfunction

   function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                              input logic [7:0]  r);
      rel_target = pc + {{8{r[7]}}, r};
   endfunction

   logic       on_carry;
   logic [2:0] bsel;
   assign on_carry = (bit_addr == CARRY_BIT_ADDR);
   assign bsel     = bit_addr[2:0];

   ////////////////////////////////////////////////////////////////////////
   // next state and results

   logic       bitv;
   logic       nbit;
   logic       bit_wr;
   logic       take;
   logic [7:0] dec_val;

   always_comb begin
      bitv           = on_carry ? carry_reg : mem_rdata[bsel];
      nbit           = bitv;
      bit_wr         = 1'b0;
      take           = 1'b0;
      dec_val        = mem_rdata - 8'h01;
      state_next     = state_reg;
      mem_addr_next  = mem_addr_reg;
      mem_sfr_next   = mem_sfr_reg;
      mem_rd_next    = 1'b0;
      mem_wr_next    = 1'b0;
      mem_wdata_next = mem_wdata_reg;
      carry_next     = carry_reg;
      pc_load_next   = 1'b0;
      pc_target_next = pc_target_reg;
      push_req_next  = 1'b0;
      push_addr_next = push_addr_reg;
      irq_done_next  = 1'b0;
      done_next      = 1'b0;
      unique case (state_reg)
         st_idle: begin
            if (start) begin
               state_next = st_exec;
               if (uses_bit(op) && !on_carry) begin
                  state_next    = st_read;
                  mem_rd_next   = 1'b1;
                  mem_addr_next = bit_byte(bit_addr);
                  mem_sfr_next  = (bit_addr >= SFR_BIT_BASE);
               end else if (op == op_count_down_branch) begin
                  state_next    = st_read;
                  mem_rd_next   = 1'b1;
                  mem_addr_next = byte_addr;
                  mem_sfr_next  = (byte_addr >= SFR_BIT_BASE);
               end
            end
         end
         st_read: begin
            state_next = st_exec;
         end
         st_exec: begin
            state_next = st_idle;
            done_next  = 1'b1;
            unique case (op)
               op_and_logic_bit:         carry_next = carry_reg & bitv;
               op_and_logic_not_bit:     carry_next = carry_reg & ~bitv;
               op_or_logic_bit:          carry_next = carry_reg | bitv;
               op_or_logic_not_bit:      carry_next = carry_reg | ~bitv;
               op_transfer_bit_to_carry: carry_next = bitv;
               op_clear_bit_carry:       carry_next = 1'b0;
               op_force_bit_high_carry:  carry_next = 1'b1;
               op_invert_bit_carry:      carry_next = ~carry_reg;
               op_transfer_carry_to_bit: begin
                  nbit   = carry_reg;
                  bit_wr = 1'b1;
               end
               op_clear_bit: begin
                  nbit   = 1'b0;
                  bit_wr = 1'b1;
               end
               op_force_bit_high: begin
                  nbit   = 1'b1;
                  bit_wr = 1'b1;
               end
               op_invert_bit: begin
                  nbit   = ~bitv;
                  bit_wr = 1'b1;
               end
               op_branch_if_carry:    take = carry_reg;
               op_branch_if_no_carry: take = ~carry_reg;
               op_branch_if_bit_high: take = bitv;
               op_branch_if_bit_low:  take = ~bitv;
               op_branch_and_clear_bit: begin
                  take   = bitv;
                  nbit   = 1'b0;
                  bit_wr = bitv;
               end
               op_short_relative_jump: take = 1'b1;
               op_long_absolute_jump: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = {addr_hi, addr_lo};
               end
               op_page_absolute_jump: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = {pc_next[15:PAGE_BITS], page_bits,
                                    addr_lo};
               end
               op_indexed_jump: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = data_pointer + {8'h00, acc};
               end
               op_long_subroutine_call: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = {addr_hi, addr_lo};
                  push_req_next  = 1'b1;
                  push_addr_next = pc_next;
               end
               op_page_subroutine_call: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = {pc_next[15:PAGE_BITS], page_bits,
                                    addr_lo};
                  push_req_next  = 1'b1;
                  push_addr_next = pc_next;
               end
               op_subroutine_exit: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = pop_addr;
               end
               op_interrupt_service_exit: begin
                  pc_load_next   = 1'b1;
                  pc_target_next = pop_addr;
                  irq_done_next  = irq_in_progress;
               end
               op_branch_acc_zero:    take = (acc == 8'h00);
               op_branch_acc_nonzero: take = (acc != 8'h00);
               op_count_down_branch: begin
                  mem_wr_next    = 1'b1;
                  mem_wdata_next = dec_val;
                  take           = (dec_val != 8'h00);
               end
               op_compare_branch_unequal: begin
                  take       = (operand_a != operand_b);
                  carry_next = (operand_a < operand_b);
               end
               default: ;
            endcase
            if (bit_wr && on_carry) begin
               carry_next = nbit;
            end else if (bit_wr) begin
               mem_wr_next    = 1'b1;
               mem_wdata_next = mem_rdata;
               mem_wdata_next[bsel] = nbit;
            end
            if (take) begin
               pc_load_next   = 1'b1;
               pc_target_next = rel_target(pc_next, rel_offset);
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= st_idle;
         mem_addr_reg  <= 8'h00;
         mem_sfr_reg   <= 1'b0;
         mem_rd_reg    <= 1'b0;
         mem_wr_reg    <= 1'b0;
         mem_wdata_reg <= 8'h00;
         carry_reg     <= CARRY_RESET;
         pc_load_reg   <= 1'b0;
         pc_target_reg <= 16'h0000;
         push_req_reg  <= 1'b0;
         push_addr_reg <= 16'h0000;
         irq_done_reg  <= 1'b0;
         done_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         mem_addr_reg  <= mem_addr_next;
         mem_sfr_reg   <= mem_sfr_next;
         mem_rd_reg    <= mem_rd_next;
         mem_wr_reg    <= mem_wr_next;
         mem_wdata_reg <= mem_wdata_next;
         carry_reg     <= carry_next;
         pc_load_reg   <= pc_load_next;
         pc_target_reg <= pc_target_next;
         push_req_reg  <= push_req_next;
         push_addr_reg <= push_addr_next;
         irq_done_reg  <= irq_done_next;
         done_reg      <= done_next;
      end
   end

   assign mem_addr  = mem_addr_reg;
   assign mem_sfr   = mem_sfr_reg;
   assign mem_rd    = mem_rd_reg;
   assign mem_wr    = mem_wr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign carry     = carry_reg;
   assign pc_load   = pc_load_reg;
   assign pc_target = pc_target_reg;
   assign push_req  = push_req_reg;
   assign push_addr = push_addr_reg;
   assign irq_done  = irq_done_reg;
   assign done      = done_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   bit_ram_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == st_idle && start && uses_bit(op) && !bit_addr[7]
      |=> mem_rd_reg && !mem_sfr_reg
          && mem_addr_reg == BIT_RAM_BASE + {4'h0, $past(bit_addr[6:3])})
      else $error("lower ram bit mapped to wrong byte");

   sfr_bit_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == st_idle && start && uses_bit(op) && bit_addr[7]
      && !on_carry
      |=> mem_rd_reg && mem_sfr_reg
          && mem_addr_reg == {$past(bit_addr[7:3]), 3'b000})
      else $error("sfr bit mapped to wrong byte");

   carry_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == st_idle && start && uses_bit(op) && on_carry
      |=> !mem_rd_reg ##1 !mem_wr_reg && done_reg)
      else $error("carry bit address touched memory");

   bit_merge_a: assert property (@(posedge mclk) disable iff (!rst_n)
      mem_wr_reg && op != op_count_down_branch
      |-> $countones(mem_wdata_reg ^ $past(mem_rdata)) <= 1)
      else $error("bit write disturbed other bits");

   rel_jump_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_short_relative_jump
      |-> pc_load_reg
          && pc_target_reg == pc_next + {{8{rel_offset[7]}}, rel_offset})
      else $error("relative target wrong");

   page_jump_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_page_absolute_jump
      |-> pc_target_reg == {pc_next[15:11], page_bits, addr_lo})
      else $error("page jump target wrong");

   index_jump_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_indexed_jump
      |-> pc_target_reg == data_pointer + {8'h00, acc})
      else $error("indexed jump target wrong");

   test_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_branch_and_clear_bit && !on_carry
      |-> pc_load_reg == $past(mem_rdata[bsel])
          && mem_wr_reg == pc_load_reg
          && (!mem_wr_reg || !mem_wdata_reg[bsel]))
      else $error("test and clear mismatch");

   count_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_count_down_branch
      |-> mem_wr_reg && mem_wdata_reg == $past(mem_rdata) - 8'h01
          && pc_load_reg == (mem_wdata_reg != 8'h00))
      else $error("count down result wrong");

   compare_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_compare_branch_unequal
      |-> carry_reg == (operand_a < operand_b)
          && pc_load_reg == (operand_a != operand_b))
      else $error("compare carry or branch wrong");

   irq_exit_a: assert property (@(posedge mclk) disable iff (!rst_n)
      done_reg && op == op_interrupt_service_exit
      |-> pc_load_reg && pc_target_reg == pop_addr
          && irq_done_reg == $past(irq_in_progress))
      else $error("interrupt exit notice wrong");

endmodule

// [testbench/data_mem_model.sv]
`timescale 1ns/1ps

module data_mem_model (
   input  wire logic       mclk,
   input  wire logic [7:0] mem_addr,
   input  wire logic       mem_sfr,
   input  wire logic       mem_rd,
   input  wire logic       mem_wr,
   input  wire logic [7:0] mem_wdata,
   output logic [7:0]      mem_rdata
);
   logic [7:0] ram [256];
   logic [7:0] sfr [256];

   initial mem_rdata = 8'h5a;

   // sync read; idle cycles show the inverse so stale data never passes
   always @(posedge mclk) begin
      if (mem_rd) begin
         mem_rdata <= mem_sfr ? sfr[mem_addr] : ram[mem_addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr && mem_sfr) begin
         sfr[mem_addr] <= mem_wdata;
      end
      if (mem_wr && !mem_sfr) begin
         ram[mem_addr] <= mem_wdata;
      end
   end
endmodule

// [testbench/tb_bit_processor_branch_unit.sv]
`timescale 1ns/1ps

module tb_bit_processor_branch_unit;
   import bit_branch_pkg::*;

   logic        mclk, rst_n, start, irq_in_progress;
   op_t         op;
   logic [7:0]  bit_addr, byte_addr, acc, operand_a, operand_b;
   logic [7:0]  rel_offset, addr_hi, addr_lo, mem_rdata, mem_addr, mem_wdata;
   logic [2:0]  page_bits;
   logic [15:0] pc_next, data_pointer, pop_addr, pc_target, push_addr;
   logic        mem_sfr, mem_rd, mem_wr, carry, pc_load, push_req;
   logic        irq_done, done;
   logic        s_ld, s_wr, s_push, s_irq;
   logic [15:0] s_tg;
   int          err_total, n_tests;

   bit_branch_unit dut_u (
      .mclk(mclk), .rst_n(rst_n), .start(start), .op(op),
      .bit_addr(bit_addr), .byte_addr(byte_addr), .acc(acc),
      .operand_a(operand_a), .operand_b(operand_b),
      .rel_offset(rel_offset), .page_bits(page_bits),
      .addr_hi(addr_hi), .addr_lo(addr_lo), .pc_next(pc_next),
      .data_pointer(data_pointer), .pop_addr(pop_addr),
      .irq_in_progress(irq_in_progress), .mem_rdata(mem_rdata),
      .mem_addr(mem_addr), .mem_sfr(mem_sfr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .carry(carry),
      .pc_load(pc_load), .pc_target(pc_target), .push_req(push_req),
      .push_addr(push_addr), .irq_done(irq_done), .done(done)
   );

   data_mem_model dm_u (
      .mclk(mclk), .mem_addr(mem_addr), .mem_sfr(mem_sfr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata)
   );

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one instruction; outputs of the done cycle are kept for the caller
   task automatic exec(input op_t o, input int lat);
      int n;
      @(negedge mclk);
      op = o;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      s_ld = pc_load;
      s_tg = pc_target;
      s_wr = mem_wr;
      s_push = push_req;
      s_irq = irq_done;
      chk("latency", lat[15:0], n[15:0]);
      // one more edge so a write has landed in memory
      @(negedge mclk);
   endtask

   task automatic bop(input op_t o, input logic [7:0] a, input logic ce);
      bit_addr = a;
      exec(o, (a == CARRY_BIT_ADDR) ? 2 : 3);
      chk("carry", 16'(ce), 16'(carry));
   endtask

   task automatic bw(input op_t o, input logic [7:0] a, input logic sp,
                     input logic [7:0] by, input logic [7:0] e);
      bit_addr = a;
      exec(o, 3);
      chk("byte", 16'(e), 16'(sp ? dm_u.sfr[by] : dm_u.ram[by]));
   endtask

   task automatic brc(input op_t o, input logic tk, input logic [15:0] tg,
                      input int lat);
      exec(o, lat);
      chk("pc_load", 16'(tk), 16'(s_ld));
      if (tk) begin
         chk("pc_target", tg, s_tg);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_bit_logic();
      dm_u.ram[8'h21] = 8'ha5;
      dm_u.sfr[8'h90] = 8'h08;
      dm_u.sfr[8'hd0] = 8'h01;
      bop(op_force_bit_high_carry, CARRY_BIT_ADDR, 1'b1);
      bop(op_and_logic_not_bit, 8'h93, 1'b0);
      bop(op_or_logic_bit, 8'h93, 1'b1);
      bop(op_and_logic_bit, 8'h0b, 1'b0);
      bop(op_or_logic_not_bit, 8'h0b, 1'b1);
      bop(op_transfer_bit_to_carry, 8'h0b, 1'b0);
      bop(op_transfer_bit_to_carry, 8'hd0, 1'b1);
      bop(op_clear_bit_carry, CARRY_BIT_ADDR, 1'b0);
      bop(op_invert_bit_carry, CARRY_BIT_ADDR, 1'b1);
      bw(op_transfer_carry_to_bit, 8'h0b, 1'b0, 8'h21, 8'had);
      bw(op_clear_bit, 8'h0b, 1'b0, 8'h21, 8'ha5);
      bw(op_force_bit_high, 8'h0b, 1'b0, 8'h21, 8'had);
      bw(op_invert_bit, 8'h0b, 1'b0, 8'h21, 8'ha5);
      bw(op_invert_bit, 8'h93, 1'b1, 8'h90, 8'h00);
   endtask

   task automatic test_bit_branch();
      pc_next = 16'h1000;
      rel_offset = 8'h80;
      bit_addr = CARRY_BIT_ADDR;
      brc(op_branch_if_bit_high, 1'b1, 16'h0f80, 2);
      brc(op_branch_if_carry, 1'b1, 16'h0f80, 2);
      brc(op_branch_if_no_carry, 1'b0, 16'h0000, 2);
      rel_offset = 8'h7f;
      bit_addr = 8'h0b;
      brc(op_branch_if_bit_low, 1'b1, 16'h107f, 3);
      brc(op_branch_if_bit_high, 1'b0, 16'h0000, 3);
      dm_u.ram[8'h2f] = 8'h81;
      bit_addr = 8'h7f;
      // test-and-clear, top ram bit
      brc(op_branch_and_clear_bit, 1'b1, 16'h107f, 3);
      chk("byte", 16'h0001, 16'(dm_u.ram[8'h2f]));
      brc(op_branch_and_clear_bit, 1'b0, 16'h0000, 3);
      chk("mem_wr", 16'h0000, 16'(s_wr));
   endtask

   task automatic test_jumps();
      pc_next = 16'h5ffe;
      rel_offset = 8'h02;
      brc(op_short_relative_jump, 1'b1, 16'h6000, 2);
      addr_hi = 8'hab;
      addr_lo = 8'hcd;
      brc(op_long_absolute_jump, 1'b1, 16'habcd, 2);
      page_bits = 3'b101;
      brc(op_page_absolute_jump, 1'b1, 16'h5dcd, 2);
      data_pointer = 16'hfff0;
      acc = 8'hf0;
      brc(op_indexed_jump, 1'b1, 16'h00e0, 2);
      brc(op_long_subroutine_call, 1'b1, 16'habcd, 2);
      chk("push", 16'h0001, 16'(s_push));
      chk("push_addr", 16'h5ffe, push_addr);
      brc(op_page_subroutine_call, 1'b1, 16'h5dcd, 2);
      pop_addr = 16'h1234;
      brc(op_subroutine_exit, 1'b1, 16'h1234, 2);
      irq_in_progress = 1'b1;
      brc(op_interrupt_service_exit, 1'b1, 16'h1234, 2);
      chk("irq_done", 16'h0001, 16'(s_irq));
      irq_in_progress = 1'b0;
      brc(op_interrupt_service_exit, 1'b1, 16'h1234, 2);
      chk("irq_done", 16'h0000, 16'(s_irq));
   endtask

   task automatic test_cond();
      pc_next = 16'h2000;
      rel_offset = 8'hfe;
      acc = 8'h00;
      brc(op_branch_acc_zero, 1'b1, 16'h1ffe, 2);
      brc(op_branch_acc_nonzero, 1'b0, 16'h0000, 2);
      acc = 8'h80;
      brc(op_branch_acc_zero, 1'b0, 16'h0000, 2);
      brc(op_branch_acc_nonzero, 1'b1, 16'h1ffe, 2);
      byte_addr = 8'h30;
      dm_u.ram[8'h30] = 8'h01;
      brc(op_count_down_branch, 1'b0, 16'h0000, 3);
      chk("count", 16'h0000, 16'(dm_u.ram[8'h30]));
      brc(op_count_down_branch, 1'b1, 16'h1ffe, 3);
      chk("count", 16'h00ff, 16'(dm_u.ram[8'h30]));
      byte_addr = 8'hf0;
      dm_u.sfr[8'hf0] = 8'h02;
      brc(op_count_down_branch, 1'b1, 16'h1ffe, 3);
      chk("count", 16'h0001, 16'(dm_u.sfr[8'hf0]));
      operand_a = 8'h10;
      operand_b = 8'h90;
      // unsigned order: a signed compare would clear carry here
      brc(op_compare_branch_unequal, 1'b1, 16'h1ffe, 2);
      chk("carry", 16'h0001, 16'(carry));
      operand_a = 8'h90;
      brc(op_compare_branch_unequal, 1'b0, 16'h0000, 2);
      chk("carry", 16'h0000, 16'(carry));
      operand_b = 8'h10;
      brc(op_compare_branch_unequal, 1'b1, 16'h1ffe, 2);
      chk("carry", 16'h0000, 16'(carry));
   endtask

   // reset in mid-run drops carry; the unit takes work again right after
   task automatic test_reset();
      bop(op_force_bit_high_carry, CARRY_BIT_ADDR, 1'b1);
      rst_n = 1'b0;
      @(negedge mclk);
      rst_n = 1'b1;
      chk("carry", 16'(CARRY_RESET), 16'(carry));
      chk("done", 16'h0000, 16'(done));
      bop(op_invert_bit_carry, CARRY_BIT_ADDR, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      print_verdict();
   end

   initial begin
      err_total = 0;
      n_tests = 0;
      rst_n = 1'b0;
      start = 1'b0;
      op = op_clear_bit_carry;
      {bit_addr, byte_addr, acc, operand_a, operand_b} = '0;
      {rel_offset, addr_hi, addr_lo, page_bits} = '0;
      {pc_next, data_pointer, pop_addr} = '0;
      irq_in_progress = 1'b0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      chk("carry", 16'(CARRY_RESET), 16'(carry));
      chk("done", 16'h0000, 16'(done));
      test_bit_logic();
      test_bit_branch();
      test_jumps();
      test_cond();
      test_reset();
      print_verdict();
   end
endmodule
